// file: rtl/ptm_timer.sv
// Period match timer core with AXI4-Lite register slave
//
// Our own choices: the AXI4-Lite interface to the registers and the register offsets.
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - 8-bit counter and 8-bit period register
// - Timer input is oscillator divided by four
// - Prescale counter divides input, 2-bit select
// - Ratios 1:1, 1:4, 1:16, 1:64
// - Compare count with period every timer clock
// - Match drives output and clocks postscaler
// - Count clears on tick after match
// - Postscaler divides matches by one to sixteen
// - Match can raise an interrupt request
// - Count and period readable and writable
// - Any reset: count zero, period all ones
// - Count or control write clears both scalers
// - Every device reset source clears both scalers
// - Control write leaves count unchanged
// - Match optionally drives serial shift clock
// - Postscale code n gives ratio n plus one
// - Prescale codes 00,01,10,11 give 1,4,16,64
// - Timer runs only while run bit set
// - Postscaler fire latches flag, enable gates it
module ptm_timer
    import ptm_pkg::*;
(
    input  wire logic        mclk,
    input  wire logic        rst,
    input  wire logic [6:0]  dev_reset_src,
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    output logic             match_out,
    output logic             ssp_shift_clk,
    output logic             irq_request
);
    typedef struct packed {
        ptm_wr_type wr_st;
        ptm_rd_type rd_st;
        logic       aw_got;
        logic       w_got;
        logic [7:0] waddr;
        logic [7:0] wbyte;
        logic       wen;
        logic [1:0] bresp;
        logic [7:0] rbyte;
        logic [1:0] rresp;
        logic [6:0] ctrl;
        logic [7:0] count;
        logic [7:0] period;
        logic [3:0] post_cnt;
        logic       flag;
        logic       irq_en;
        logic       ssp_en;
        logic       match;
        logic       ssp_clk;
    } ptm_state_type;

    ptm_state_type st_ff;
    ptm_state_type nxt_st;
    ptm_sel_type   wsel;
    ptm_sel_type   rsel;
    logic          any_rst;
    logic          wr_go;
    logic          wr_ctl;
    logic          wr_cnt;
    logic          wr_per;
    logic          wr_irq;
    logic          eq;
    logic          fire;
    logic [3:0]    post_sel;
    logic [7:0]    rd_val;

    ptm_tick_if tif ();

    // Register address decode, shared by read and write paths
    function automatic ptm_sel_type ptm_reg_sel(input logic [7:0] addr);
        if (addr == PTM_ADDR_CTRL) begin
            return PTM_SEL_CTRL;
        end else if (addr == PTM_ADDR_COUNT) begin
            return PTM_SEL_COUNT;
        end else if (addr == PTM_ADDR_PERIOD) begin
            return PTM_SEL_PERIOD;
        end else if (addr == PTM_ADDR_IRQ) begin
            return PTM_SEL_IRQ;
        end else begin
            return PTM_SEL_NONE;
        end
    endfunction

    ptm_scaler u_scaler (
        .mclk (mclk),
        .rst  (rst),
        .tif  (tif)
    );

    // Every reset source acts on the timer state
    assign any_rst = rst || (|dev_reset_src);

    // Write is performed once both address and data are held
    assign wsel   = ptm_reg_sel(st_ff.waddr);
    assign wr_go  = st_ff.wr_st == PTM_WR_IDLE && st_ff.aw_got && st_ff.w_got;
    assign wr_ctl = wr_go && st_ff.wen && wsel == PTM_SEL_CTRL;
    assign wr_cnt = wr_go && st_ff.wen && wsel == PTM_SEL_COUNT;
    assign wr_per = wr_go && st_ff.wen && wsel == PTM_SEL_PERIOD;
    assign wr_irq = wr_go && st_ff.wen && wsel == PTM_SEL_IRQ;

    // Scaler control
    assign tif.clear     = any_rst || wr_ctl || wr_cnt;
    assign tif.run       = st_ff.ctrl[PTM_RUN_BIT];
    assign tif.presc_sel = st_ff.ctrl[PTM_PRE_MSB:PTM_PRE_LSB];
    assign post_sel      = st_ff.ctrl[PTM_POST_MSB:PTM_POST_LSB];

    // Match compare and postscaler fire
    assign eq   = st_ff.count == st_ff.period;
    assign fire = tif.tick && eq && !tif.clear && st_ff.post_cnt == post_sel;

    // Read mux; bits above the register width read zero
    assign rsel = ptm_reg_sel(s_axi_araddr);
    always_comb begin
        rd_val = 8'h00;
        if (rsel == PTM_SEL_CTRL) begin
            rd_val = {1'b0, st_ff.ctrl};
        end else if (rsel == PTM_SEL_COUNT) begin
            rd_val = st_ff.count;
        end else if (rsel == PTM_SEL_PERIOD) begin
            rd_val = st_ff.period;
        end else if (rsel == PTM_SEL_IRQ) begin
            rd_val = {5'h00, st_ff.ssp_en, st_ff.irq_en, st_ff.flag};
        end
    end

    // Bus handshakes
    assign s_axi_awready = !st_ff.aw_got && st_ff.wr_st == PTM_WR_IDLE;
    assign s_axi_wready  = !st_ff.w_got && st_ff.wr_st == PTM_WR_IDLE;
    assign s_axi_bvalid  = st_ff.wr_st == PTM_WR_RESP;
    assign s_axi_bresp   = st_ff.bresp;
    assign s_axi_arready = st_ff.rd_st == PTM_RD_IDLE;
    assign s_axi_rvalid  = st_ff.rd_st == PTM_RD_DATA;
    assign s_axi_rdata   = {24'h000000, st_ff.rbyte};
    assign s_axi_rresp   = st_ff.rresp;

    // Timer outputs
    assign match_out     = st_ff.match;
    assign ssp_shift_clk = st_ff.ssp_clk;
    assign irq_request   = st_ff.flag && st_ff.irq_en;

    // Next state for bus, timer and registers
    always_comb begin
        nxt_st = st_ff;
        nxt_st.match = 1'b0;
        nxt_st.ssp_clk = 1'b0;
        // Address and data may arrive in either order
        if (s_axi_awvalid && s_axi_awready) begin
            nxt_st.aw_got = 1'b1;
            nxt_st.waddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            nxt_st.w_got = 1'b1;
            nxt_st.wbyte = s_axi_wdata[7:0];
            nxt_st.wen = s_axi_wstrb[0];
        end
        case (st_ff.wr_st)
            PTM_WR_IDLE: begin
                if (wr_go) begin
                    nxt_st.wr_st = PTM_WR_RESP;
                    nxt_st.bresp = (wsel == PTM_SEL_NONE) ? PTM_RESP_SLVERR : PTM_RESP_OKAY;
                end
            end
            PTM_WR_RESP: begin
                if (s_axi_bready) begin
                    nxt_st.wr_st = PTM_WR_IDLE;
                    nxt_st.aw_got = 1'b0;
                    nxt_st.w_got = 1'b0;
                end
            end
            default: begin
                nxt_st.wr_st = PTM_WR_IDLE;
            end
        endcase
        case (st_ff.rd_st)
            PTM_RD_IDLE: begin
                if (s_axi_arvalid) begin
                    nxt_st.rd_st = PTM_RD_DATA;
                    nxt_st.rbyte = rd_val;
                    nxt_st.rresp = (rsel == PTM_SEL_NONE) ? PTM_RESP_SLVERR : PTM_RESP_OKAY;
                end
            end
            PTM_RD_DATA: begin
                if (s_axi_rready) begin
                    nxt_st.rd_st = PTM_RD_IDLE;
                end
            end
            default: begin
                nxt_st.rd_st = PTM_RD_IDLE;
            end
        endcase
        // Counting; ticks only arrive while the run bit is set
        if (tif.tick) begin
            if (eq) begin
                nxt_st.count = PTM_COUNT_RST;
                nxt_st.match = 1'b1;
                nxt_st.ssp_clk = st_ff.ssp_en;
                if (!tif.clear) begin
                    nxt_st.post_cnt = fire ? 4'h0 : st_ff.post_cnt + 4'h1;
                end
            end else begin
                nxt_st.count = st_ff.count + 8'h01;
            end
        end
        if (tif.clear) begin
            nxt_st.post_cnt = 4'h0;
        end
        // Software writes win over counting; control leaves count alone
        if (wr_ctl) begin
            nxt_st.ctrl = st_ff.wbyte[6:0];
        end
        if (wr_cnt) begin
            nxt_st.count = st_ff.wbyte;
        end
        if (wr_per) begin
            nxt_st.period = st_ff.wbyte;
        end
        if (wr_irq) begin
            if (st_ff.wbyte[PTM_FLAG_BIT]) begin
                nxt_st.flag = 1'b0;
            end
            nxt_st.irq_en = st_ff.wbyte[PTM_IEN_BIT];
            nxt_st.ssp_en = st_ff.wbyte[PTM_SSP_BIT];
        end
        // A fire in the clearing cycle is not lost
        if (fire) begin
            nxt_st.flag = 1'b1;
        end
        if (any_rst) begin
            nxt_st.count = PTM_COUNT_RST;
            nxt_st.period = PTM_PERIOD_RST;
            nxt_st.ctrl = PTM_CTRL_RST;
            nxt_st.post_cnt = 4'h0;
            nxt_st.flag = 1'b0;
            nxt_st.irq_en = 1'b0;
            nxt_st.ssp_en = 1'b0;
            nxt_st.match = 1'b0;
            nxt_st.ssp_clk = 1'b0;
        end
        if (rst) begin
            nxt_st.wr_st = PTM_WR_IDLE;
            nxt_st.rd_st = PTM_RD_IDLE;
            nxt_st.aw_got = 1'b0;
            nxt_st.w_got = 1'b0;
            nxt_st.waddr = 8'h00;
            nxt_st.wbyte = 8'h00;
            nxt_st.wen = 1'b0;
            nxt_st.bresp = PTM_RESP_OKAY;
            nxt_st.rbyte = 8'h00;
            nxt_st.rresp = PTM_RESP_OKAY;
        end
    end

    // State register
    always_ff @(posedge mclk) begin
        st_ff <= nxt_st;
    end

    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);

    sequence tick_at_period;
        tif.tick && eq && !wr_cnt && !any_rst;
    endsequence
    sequence tick_below_period;
        tif.tick && !eq && !wr_cnt && !any_rst;
    endsequence

    count_wrap_a: assert property (tick_at_period |=> st_ff.count == 8'h00)
        else $error("count not cleared after match");
    count_inc_a: assert property (
        tick_below_period |=> st_ff.count == $past(st_ff.count) + 8'h01)
        else $error("count did not advance by one");
    match_pulse_a: assert property (
        tick_at_period |=> match_out ##1 !match_out)
        else $error("match pulse missing or too long");
    stop_hold_a: assert property (
        !tif.run && !tif.tick && !wr_cnt && !any_rst |=> $stable(st_ff.count))
        else $error("count moved while stopped");
    reset_val_a: assert property (
        |dev_reset_src |=> st_ff.count == 8'h00 && st_ff.period == 8'hff)
        else $error("reset values wrong");
    ctrl_keep_a: assert property (
        wr_ctl && !tif.tick && !any_rst |=> $stable(st_ff.count))
        else $error("control write changed count");
    flag_set_a: assert property (fire && !any_rst |=> st_ff.flag)
        else $error("flag not set on postscaler fire");
    post_clear_a: assert property (tif.clear |=> st_ff.post_cnt == 4'h0)
        else $error("postscaler not cleared");
    irq_gate_a: assert property (
        fire && st_ff.irq_en && !wr_irq && !any_rst |=> irq_request)
        else $error("interrupt not raised");
endmodule
`default_nettype wire

// file: rtl/ptm_pkg.sv
// Shared constants, register map and helpers for the period match timer
package ptm_pkg;
    // Register byte addresses on the AXI4-Lite slave
    localparam logic [7:0] PTM_ADDR_CTRL   = 8'h00;
    localparam logic [7:0] PTM_ADDR_COUNT  = 8'h04;
    localparam logic [7:0] PTM_ADDR_PERIOD = 8'h08;
    localparam logic [7:0] PTM_ADDR_IRQ    = 8'h0c;
    // Control field positions
    localparam int PTM_POST_LSB = 3;
    localparam int PTM_POST_MSB = 6;
    localparam int PTM_RUN_BIT  = 2;
    localparam int PTM_PRE_LSB  = 0;
    localparam int PTM_PRE_MSB  = 1;
    // Interrupt register field positions
    localparam int PTM_FLAG_BIT = 0;
    localparam int PTM_IEN_BIT  = 1;
    localparam int PTM_SSP_BIT  = 2;
    // Reset values
    localparam logic [6:0] PTM_CTRL_RST   = 7'h00;
    localparam logic [7:0] PTM_COUNT_RST  = 8'h00;
    localparam logic [7:0] PTM_PERIOD_RST = 8'hff;
    // Timing: instruction clock is the oscillator divided by four
    localparam int         PTM_MCLK_NS  = 10;
    localparam int         PTM_INST_DIV = 4;
    localparam logic [1:0] PTM_INST_LAST = 2'(PTM_INST_DIV - 1);
    // Prescale select codes
    localparam logic [1:0] PTM_PRE_1  = 2'h0;
    localparam logic [1:0] PTM_PRE_4  = 2'h1;
    localparam logic [1:0] PTM_PRE_16 = 2'h2;
    // AXI responses
    localparam logic [1:0] PTM_RESP_OKAY   = 2'h0;
    localparam logic [1:0] PTM_RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {PTM_WR_IDLE = 2'b01, PTM_WR_RESP = 2'b10} ptm_wr_type;
    typedef enum logic [1:0] {PTM_RD_IDLE = 2'b01, PTM_RD_DATA = 2'b10} ptm_rd_type;
    typedef enum logic [4:0] {
        PTM_SEL_NONE = 5'b00001, PTM_SEL_CTRL = 5'b00010, PTM_SEL_COUNT = 5'b00100,
        PTM_SEL_PERIOD = 5'b01000, PTM_SEL_IRQ = 5'b10000
    } ptm_sel_type;

    // Last prescale count for each select code
    function automatic logic [5:0] ptm_presc_last(input logic [1:0] sel);
        if (sel == PTM_PRE_1) begin
            return 6'h00;
        end else if (sel == PTM_PRE_4) begin
            return 6'h03;
        end else if (sel == PTM_PRE_16) begin
            return 6'h0f;
        end else begin
            return 6'h3f;
        end
    endfunction
endpackage

// file: rtl/ptm_tick_if.sv
// Carrier between the timer core and its prescaler
`timescale 1ns/1ps
`default_nettype none
interface ptm_tick_if;
    logic       clear;
    logic       run;
    logic [1:0] presc_sel;
    logic       tick;
    modport ctl (output clear, output run, output presc_sel, input tick);
    modport scl (input clear, input run, input presc_sel, output tick);
endinterface
`default_nettype wire

// file: rtl/ptm_scaler.sv
// Instruction clock divider and selectable prescaler for the timer
`timescale 1ns/1ps
`default_nettype none
module ptm_scaler
    import ptm_pkg::*;
(
    input  wire logic mclk,
    input  wire logic rst,
    ptm_tick_if.scl   tif
);
    typedef struct packed {
        logic [1:0] inst_cnt;
        logic [5:0] presc_cnt;
        logic       tick;
    } ptm_scl_type;

    ptm_scl_type st_ff;
    ptm_scl_type nxt_st;
    logic        inst;

    assign inst = st_ff.inst_cnt == PTM_INST_LAST;
    assign tif.tick = st_ff.tick;

    // Divider free-runs so the timer phase does not jump on control writes
    always_comb begin
        nxt_st = st_ff;
        nxt_st.tick = 1'b0;
        nxt_st.inst_cnt = inst ? 2'h0 : st_ff.inst_cnt + 2'h1;
        if (tif.clear) begin
            nxt_st.presc_cnt = 6'h00;
        end else if (tif.run && inst) begin
            if (st_ff.presc_cnt == ptm_presc_last(tif.presc_sel)) begin
                nxt_st.presc_cnt = 6'h00;
                nxt_st.tick = 1'b1;
            end else begin
                nxt_st.presc_cnt = st_ff.presc_cnt + 6'h01;
            end
        end
        if (rst) begin
            nxt_st = '0;
        end
    end

    // State register
    always_ff @(posedge mclk) begin
        st_ff <= nxt_st;
    end

    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);

    sequence inst_quiet;
        !inst [*3] ##1 inst;
    endsequence
    inst_gap_a: assert property (inst |=> inst_quiet)
        else $error("instruction tick spacing is not four clocks");
    presc_bound_a: assert property (
        st_ff.presc_cnt <= ptm_presc_last(tif.presc_sel))
        else $error("prescale count beyond selected ratio");
    presc_clear_a: assert property (
        tif.clear |=> st_ff.presc_cnt == 6'h00 && !tif.tick)
        else $error("prescaler not cleared");
endmodule
`default_nettype wire

// file: testbench/period_match_timer8_test.sv
// Self-checking bench for the period match timer and its register slave
`timescale 1ns/1ps
`default_nettype none
module period_match_timer8_test
    import ptm_pkg::*;
;
    logic        mclk = 1'h0;
    logic        rst;
    logic [6:0]  dev_reset_src;
    logic [7:0]  s_axi_awaddr;
    logic        s_axi_awvalid;
    logic        s_axi_awready;
    logic [31:0] s_axi_wdata;
    logic [3:0]  s_axi_wstrb;
    logic        s_axi_wvalid;
    logic        s_axi_wready;
    logic [1:0]  s_axi_bresp;
    logic        s_axi_bvalid;
    logic        s_axi_bready;
    logic [7:0]  s_axi_araddr;
    logic        s_axi_arvalid;
    logic        s_axi_arready;
    logic [31:0] s_axi_rdata;
    logic [1:0]  s_axi_rresp;
    logic        s_axi_rvalid;
    logic        s_axi_rready;
    logic        match_out;
    logic        ssp_shift_clk;
    logic        irq_request;
    int          err_count;
    int          check_count;
    logic [31:0] rd_data;
    logic [1:0]  rd_resp;
    logic [1:0]  wr_resp;
    int          gap;

    ptm_timer DUT (
        .mclk(mclk), .rst(rst), .dev_reset_src(dev_reset_src),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready), .match_out(match_out),
        .ssp_shift_clk(ssp_shift_clk), .irq_request(irq_request)
    );

    // 100 MHz oscillator clock
    always #5 mclk = ~mclk;

    // Verdict and end of run
    task automatic tally_and_finish;
        if (err_count == 0 && check_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // Four-state compare, so an unknown never matches
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
            err_count++;
        end
    endtask

    // One write; address and data offered together, each dropped once taken
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk);
        s_axi_awaddr  <= a;
        s_axi_awvalid <= 1'h1;
        s_axi_wdata   <= d;
        s_axi_wvalid  <= 1'h1;
        s_axi_bready  <= 1'h1;
        do begin
            @(posedge mclk);
            if (s_axi_awready === 1'h1) s_axi_awvalid <= 1'h0;
            if (s_axi_wready === 1'h1) s_axi_wvalid <= 1'h0;
        end while (s_axi_bvalid !== 1'h1);
        wr_resp = s_axi_bresp;
        s_axi_bready <= 1'h0;
    endtask

    // One read; data and response taken at the rvalid edge
    task automatic axi_read(input logic [7:0] a);
        @(posedge mclk);
        s_axi_araddr  <= a;
        s_axi_arvalid <= 1'h1;
        s_axi_rready  <= 1'h1;
        do begin
            @(posedge mclk);
            if (s_axi_arready === 1'h1) s_axi_arvalid <= 1'h0;
        end while (s_axi_rvalid !== 1'h1);
        rd_data = s_axi_rdata;
        rd_resp = s_axi_rresp;
        s_axi_rready <= 1'h0;
    endtask

    task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
        axi_read(a);
        chk(rd_data, e);
    endtask

    // Cycles until the next match pulse is seen
    task automatic wait_match(output int n);
        n = 0;
        do begin
            @(posedge mclk);
            n++;
        end while (match_out !== 1'h1);
    endtask

    // Register values straight after reset, unmapped read
    task automatic t_reset;
        rdchk(PTM_ADDR_CTRL, 32'h0);
        rdchk(PTM_ADDR_COUNT, 32'h0);
        rdchk(PTM_ADDR_PERIOD, 32'hff);
        rdchk(PTM_ADDR_IRQ, 32'h0);
        rdchk(8'h10, 32'h0);
        chk(32'(rd_resp), 32'(PTM_RESP_SLVERR));
    endtask

    // Read-back of count and period; only eight bits are held
    task automatic t_regs;
        wr(PTM_ADDR_PERIOD, 32'h15a);
        rdchk(PTM_ADDR_PERIOD, 32'h5a);
        wr(PTM_ADDR_COUNT, 32'h233);
        rdchk(PTM_ADDR_COUNT, 32'h33);
        wr(8'h14, 32'h1);
        chk(32'(wr_resp), 32'(PTM_RESP_SLVERR));
        // Low byte lane off: write dropped, still answered OKAY
        s_axi_wstrb <= 4'h0;
        wr(PTM_ADDR_COUNT, 32'h55);
        s_axi_wstrb <= 4'hf;
        chk(32'(wr_resp), 32'(PTM_RESP_OKAY));
        rdchk(PTM_ADDR_COUNT, 32'h33);
    endtask

    // Every prescale code; the first gap shows the control write cleared it
    task automatic t_presc;
        wr(PTM_ADDR_PERIOD, 32'h0);
        wr(PTM_ADDR_COUNT, 32'h0);
        for (int s = 0; s < 4; s++) begin
            wr(PTM_ADDR_CTRL, 32'(s) | 32'h4);
            wait_match(gap);
            chk(32'(gap >= (4 << (2 * s)) - 8), 32'h1);
            wait_match(gap);
            chk(32'(gap), 32'(4 << (2 * s)));
        end
    endtask

    // Match spacing is period plus one timer ticks
    task automatic t_period;
        int p[2] = '{2, 9};
        wr(PTM_ADDR_CTRL, 32'h4);
        foreach (p[i]) begin
            wr(PTM_ADDR_PERIOD, 32'(p[i]));
            wait_match(gap);
            wait_match(gap);
            chk(32'(gap), 32'(4 * (p[i] + 1)));
        end
    endtask

    // Stopped count holds, control write keeps it, running count climbs
    task automatic t_run;
        logic [31:0] held;
        wr(PTM_ADDR_CTRL, 32'h0);
        axi_read(PTM_ADDR_COUNT);
        held = rd_data;
        repeat (40) @(posedge mclk);
        rdchk(PTM_ADDR_COUNT, held);
        wr(PTM_ADDR_COUNT, 32'h7);
        wr(PTM_ADDR_CTRL, 32'h2);
        rdchk(PTM_ADDR_COUNT, 32'h7);
        wr(PTM_ADDR_PERIOD, 32'hff);
        wr(PTM_ADDR_CTRL, 32'h4);
        repeat (40) @(posedge mclk);
        wr(PTM_ADDR_CTRL, 32'h0);
        axi_read(PTM_ADDR_COUNT);
        // Bus overhead makes the exact tick count vary by one or two
        chk(32'(rd_data >= 32'h0f && rd_data <= 32'h14), 32'h1);
    endtask

    // Postscaler boundary codes and code 5, then a masked flag
    task automatic t_post;
        int codes[3] = '{0, 5, 15};
        int n;
        wr(PTM_ADDR_PERIOD, 32'h0);
        foreach (codes[i]) begin
            wr(PTM_ADDR_CTRL, 32'h0);
            wr(PTM_ADDR_IRQ, 32'h3);
            rdchk(PTM_ADDR_IRQ, 32'h2);
            wr(PTM_ADDR_CTRL, 32'(codes[i] << 3) | 32'h4);
            n = 0;
            do begin
                wait_match(gap);
                n++;
            end while (irq_request !== 1'h1 && n < 20);
            chk(32'(n), 32'(codes[i] + 1));
        end
        // Every match fires at 1:1, so the flag sets again while masked
        wr(PTM_ADDR_CTRL, 32'h4);
        wr(PTM_ADDR_IRQ, 32'h1);
        wait_match(gap);
        wait_match(gap);
        chk(32'(irq_request), 32'h0);
        rdchk(PTM_ADDR_IRQ, 32'h1);
    endtask

    // Serial shift clock follows the match only while enabled
    task automatic t_ssp;
        wr(PTM_ADDR_IRQ, 32'h4);
        wait_match(gap);
        chk(32'(ssp_shift_clk), 32'h1);
        wr(PTM_ADDR_IRQ, 32'h0);
        wait_match(gap);
        chk(32'(ssp_shift_clk), 32'h0);
    endtask

    // Each device reset source on its own, one edge long
    task automatic t_devrst;
        for (int i = 0; i < 7; i++) begin
            wr(PTM_ADDR_PERIOD, 32'h21);
            wr(PTM_ADDR_COUNT, 32'h11);
            wr(PTM_ADDR_CTRL, 32'h0e);
            dev_reset_src <= 7'(1 << i);
            @(posedge mclk);
            dev_reset_src <= 7'h0;
            rdchk(PTM_ADDR_COUNT, 32'h0);
            rdchk(PTM_ADDR_PERIOD, 32'hff);
            rdchk(PTM_ADDR_CTRL, 32'h0);
        end
    endtask

    // Main sequence
    initial begin
        rst           = 1'h1;
        dev_reset_src = 7'h0;
        s_axi_awaddr  = 8'h0;
        s_axi_awvalid = 1'h0;
        s_axi_wdata   = 32'h0;
        s_axi_wstrb   = 4'hf;
        s_axi_wvalid  = 1'h0;
        s_axi_bready  = 1'h0;
        s_axi_araddr  = 8'h0;
        s_axi_arvalid = 1'h0;
        s_axi_rready  = 1'h0;
        err_count     = 0;
        check_count   = 0;
        repeat (12) @(posedge mclk);
        rst <= 1'h0;
        t_reset();
        t_regs();
        t_presc();
        t_period();
        t_run();
        t_post();
        t_ssp();
        t_devrst();
        tally_and_finish();
    end

    // Watchdog, well past the few thousand cycles the tests need
    initial begin
        #400000;
        err_count++;
        tally_and_finish();
    end
endmodule
`default_nettype wire
